// ===== rtl/pll_ctrl_top.sv
// digital control core of the integer-N synthesizer
// Function
// - feedback count is main times modulus plus swallow
// - 10-bit reference counter makes comparison tick
// - lock high when edges within about 5 ns
// - pump level equals current code plus one
// - source follows up, sink follows down
// - start bit begins search, pump held mid
// - search 32 sub-bands, keep nearest to target
// - finish clears start bit, pump re-enabled
// - calibration takes about seven comparison periods
// - lock falling edge restarts calibration when armed and idle
// - enable bit arms automatic restart on lock loss
// - two-bit swing code picks one of four levels
// - path field picks direct, divide-two or divide-four
// - pin mode zero: pin powers whole device down
// - pin mode one: pin gates output stage only
// - strap selects host bus, ground I2C, supply SPI
`timescale 1ns/1ps
`include "pll_ctrl_defines.svh"

module pll_ctrl_top (
    input wire logic mclk, // core clock, 250 MHz
    input wire logic rst_n, // async reset, active low
    input wire logic ref_clk_pin, // reference clock pin
    input wire logic presc_out_pin, // prescaler output pin
    input wire logic ext_shutdown_pin, // power-down pin, high = off
    input wire logic host_iface_strap, // strap, 1 = SPI, 0 = I2C
    input wire logic [`RDIV_W-1:0] ref_div_ratio, // reference ratio
    input wire logic [`MAIN_W-1:0] main_count, // main counter ratio
    input wire logic [`SWAL_W-1:0] swallow_count, // swallow ratio
    input wire logic modulus_19_sel, // 1 = 19/20, 0 = 16/17
    input wire logic cal_start_write, // pulse: one written to start
    input wire logic cal_restart_enable, // arm restart on lock loss
    input wire logic cp_current_code_b2, // pump code bit 2
    input wire logic cp_current_code_b1, // pump code bit 1
    input wire logic cp_current_code_b0, // pump code bit 0
    input wire logic vco_swing_hi, // swing code bit 1
    input wire logic vco_swing_lo, // swing code bit 0
    input wire logic [4:0] output_path_field, // path and power field
    input wire logic pin_mode_select, // 0 device pd, 1 output gate
    output logic modulus_19, // prescaler modulus select
    output logic modulus_ctrl, // prescaler P+1 request
    output logic pfd_up, // detector up pulse
    output logic pfd_down, // detector down pulse
    output logic lock_detect, // high when locked
    output logic pump_source_on, // sourcing current on
    output logic pump_sink_on, // sinking current on
    output logic [`CP_LEVEL_W-1:0] pump_level, // units of min current
    output logic pump_mid_hold, // pump and tune node at half supply
    output logic vco_cal_start, // start bit as read back
    output logic [`BAND_W-1:0] vco_band, // selected sub-band
    output logic [1:0] vco_swing, // amplitude level
    output logic path_direct, // direct output path on
    output logic path_div2, // divide-by-two path on
    output logic path_div4, // divide-by-four path on
    output logic device_off, // whole device powered down
    output logic output_stage_off, // output stage gated off
    output logic host_iface_spi // latched strap, 1 = SPI
);

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [`PIN_CNT-1:0] pin_raw;
    logic [`PIN_CNT-1:0] pin_level;
    logic [`PIN_CNT-1:0] pin_rise;

    assign pin_raw = {host_iface_strap, ext_shutdown_pin,
                      presc_out_pin, ref_clk_pin};

    // three stages; a change counts only once stages two and three agree
    generate
        for (genvar gi = 0; gi < `PIN_CNT; gi++) begin : g_sync
            logic s1_q;
            logic s2_q;
            logic s3_q;
            logic stab_q;
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                    stab_q <= 1'b0;
                end else begin
                    s1_q <= pin_raw[gi];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        stab_q <= s3_q;
                    end
                end
            end
            assign pin_level[gi] = stab_q;
            assign pin_rise[gi] = s2_q && s3_q && !stab_q;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // reference divider
    logic [`RDIV_W-1:0] rcnt_q;
    logic [`RDIV_W-1:0] rlimit;
    logic ref_tick_q;

    // ratio zero would underflow, treat it as divide by one
    assign rlimit = (ref_div_ratio == '0) ? '0 :
                    ref_div_ratio - `RDIV_W'(1);

    // reference edges are sampled, so input rate is limited to mclk/4
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rcnt_q <= '0;
            ref_tick_q <= 1'b0;
        end else begin
            ref_tick_q <= 1'b0;
            if (pin_rise[`PIN_REF]) begin
                if (rcnt_q >= rlimit) begin
                    rcnt_q <= '0;
                    ref_tick_q <= 1'b1;
                end else begin
                    rcnt_q <= rcnt_q + `RDIV_W'(1);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // feedback divider
    fb_div_if fb ();
    logic modulus_19_q;
    logic modulus_ctrl_q;

    assign fb.main_count = main_count;
    assign fb.swallow_count = swallow_count;
    assign fb.presc_edge = pin_rise[`PIN_PRESC];

    fb_divider u_fb (
        .mclk (mclk),
        .rst_n (rst_n),
        .bus (fb.div)
    );

    // modulus select and per-cycle modulus control to the prescaler
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            modulus_19_q <= 1'b0;
            modulus_ctrl_q <= 1'b0;
        end else begin
            modulus_19_q <= modulus_19_sel;
            modulus_ctrl_q <= fb.mod_ctrl;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // phase detector and lock detect
    logic up_q;
    logic dn_q;
    logic both;
    logic [`GAP_W-1:0] gap_q;
    logic lock_q;

    assign both = up_q && dn_q;

    // both high for one cycle acts as the anti-backlash reset
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            up_q <= 1'b0;
            dn_q <= 1'b0;
        end else begin
            up_q <= (up_q && !both) || ref_tick_q;
            dn_q <= (dn_q && !both) || fb.fb_tick;
        end
    end

    // gap counts cycles between the two rising edges
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            gap_q <= '0;
            lock_q <= 1'b0;
        end else if (both) begin
            gap_q <= '0;
            lock_q <= (gap_q <= `LOCK_WIN_CYC);
        end else if ((up_q ^ dn_q) && (gap_q != '1)) begin
            gap_q <= gap_q + `GAP_W'(1);
        end
    end

    a_lock_tight: assert property (@(posedge mclk) disable iff (!rst_n)
        both && gap_q <= `LOCK_WIN_CYC |=> lock_q)
        else $error("close edges did not show lock");
    a_lock_loose: assert property (@(posedge mclk) disable iff (!rst_n)
        both && gap_q > `LOCK_WIN_CYC |=> !lock_q)
        else $error("distant edges did not show unlock");

    ////////////////////////////////////////////////////////////////////
    // calibration sequencer, steps on comparison ticks
    pll_ctrl_pkg::cal_state_t state_q;
    pll_ctrl_pkg::cal_state_t state_d;
    pll_ctrl_pkg::band_t band_q;
    pll_ctrl_pkg::band_t bit_q;
    logic [1:0] fbcnt_q;
    logic lock_tick_q;
    logic restart_trig;
    logic cal_flag_q;
    logic fast;
    logic cal_busy_d;

    // lock seen per comparison period, so one fall gives one trigger
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lock_tick_q <= 1'b0;
        end else if (ref_tick_q) begin
            lock_tick_q <= lock_q;
        end
    end

    assign restart_trig = cal_restart_enable && ref_tick_q &&
                          lock_tick_q && !lock_q;

    // feedback ticks per comparison period, saturating at two
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fbcnt_q <= '0;
        end else if (ref_tick_q) begin
            fbcnt_q <= {1'b0, fb.fb_tick};
        end else if (fb.fb_tick && fbcnt_q != 2'h2) begin
            fbcnt_q <= fbcnt_q + 2'h1;
        end
    end

    // more than one feedback tick per period: band runs too fast
    assign fast = (fbcnt_q == 2'h2);

    // a new write restarts the run at once; a lock fall only when idle
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            pll_ctrl_pkg::CAL_IDLE: begin
                if (restart_trig) begin
                    state_d = pll_ctrl_pkg::CAL_SETTLE;
                end
            end
            pll_ctrl_pkg::CAL_SETTLE: begin
                if (ref_tick_q) begin
                    state_d = pll_ctrl_pkg::CAL_SEARCH;
                end
            end
            pll_ctrl_pkg::CAL_SEARCH: begin
                if (ref_tick_q && bit_q == 5'h01) begin
                    state_d = pll_ctrl_pkg::CAL_FINISH;
                end
            end
            pll_ctrl_pkg::CAL_FINISH: begin
                if (ref_tick_q) begin
                    state_d = pll_ctrl_pkg::CAL_IDLE;
                end
            end
        endcase
        if (cal_start_write) begin
            state_d = pll_ctrl_pkg::CAL_SETTLE;
        end
    end

    assign cal_busy_d = (state_d != pll_ctrl_pkg::CAL_IDLE);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= pll_ctrl_pkg::CAL_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // successive approximation over 32 bands, five trial bits
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            band_q <= `BAND_INIT;
            bit_q <= `BAND_BIT_INIT;
        end else if (state_d == pll_ctrl_pkg::CAL_SETTLE) begin
            band_q <= `BAND_INIT;
            bit_q <= `BAND_BIT_INIT;
        end else if (state_q == pll_ctrl_pkg::CAL_SEARCH && ref_tick_q) begin
            band_q <= (fast ? (band_q & ~bit_q) : band_q)
                      | (bit_q >> 1);
            bit_q <= bit_q >> 1;
        end
    end

    // set wins over the self-clear at finish
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cal_flag_q <= 1'b0;
        end else if (cal_start_write ||
                     (restart_trig && state_q == pll_ctrl_pkg::CAL_IDLE)) begin
            cal_flag_q <= 1'b1;
        end else if (state_q == pll_ctrl_pkg::CAL_FINISH && ref_tick_q) begin
            cal_flag_q <= 1'b0;
        end
    end

    // helper: comparison ticks seen during one run
    logic [3:0] cal_ticks_q;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cal_ticks_q <= '0;
        end else if (state_q == pll_ctrl_pkg::CAL_IDLE ||
                     cal_start_write) begin
            cal_ticks_q <= '0;
        end else if (ref_tick_q) begin
            cal_ticks_q <= cal_ticks_q + 4'h1;
        end
    end

    a_cal_length: assert property (@(posedge mclk) disable iff (!rst_n)
        state_q == pll_ctrl_pkg::CAL_FINISH && ref_tick_q
        && !cal_start_write |-> cal_ticks_q == 4'(`CAL_PERIODS - 1))
        else $error("calibration length not seven periods");
    a_cal_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        state_q == pll_ctrl_pkg::CAL_FINISH && ref_tick_q
        && !cal_start_write |=> !cal_flag_q && !pump_mid_hold)
        else $error("finish did not clear start bit");
    a_restart_go: assert property (@(posedge mclk) disable iff (!rst_n)
        state_q == pll_ctrl_pkg::CAL_IDLE && restart_trig
        |=> state_q == pll_ctrl_pkg::CAL_SETTLE && cal_flag_q)
        else $error("lock loss did not restart calibration");

    ////////////////////////////////////////////////////////////////////
    // charge pump drive
    logic src_q;
    logic snk_q;
    logic hold_q;
    logic [`CP_LEVEL_W-1:0] level_q;
    logic [`CP_CODE_W-1:0] cp_code;

    assign cp_code = {cp_current_code_b2, cp_current_code_b1,
                      cp_current_code_b0};

    // pump inhibited and parked at half supply while a run is active
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            src_q <= 1'b0;
            snk_q <= 1'b0;
            hold_q <= 1'b0;
            level_q <= `CP_LEVEL_W'(1);
        end else begin
            src_q <= up_q && !cal_busy_d;
            snk_q <= dn_q && !cal_busy_d;
            hold_q <= cal_busy_d;
            level_q <= {1'b0, cp_code} + `CP_LEVEL_W'(1);
        end
    end

    a_pump_inhibit: assert property (@(posedge mclk) disable iff (!rst_n)
        hold_q |-> !src_q && !snk_q)
        else $error("pump active during calibration");
    a_pump_follow: assert property (@(posedge mclk) disable iff (!rst_n)
        !hold_q |-> src_q == $past(up_q) && snk_q == $past(dn_q))
        else $error("pump not following detector");
    a_pump_level: assert property (@(posedge mclk) disable iff (!rst_n)
        ##1 level_q == {1'b0, $past(cp_code)} + `CP_LEVEL_W'(1))
        else $error("pump level not code plus one");

    ////////////////////////////////////////////////////////////////////
    // swing, output path, power-down pin and strap
    logic [1:0] swing_q;
    logic dir_q;
    logic d2_q;
    logic d4_q;
    logic off_q;
    logic out_off_q;
    logic [2:0] strap_wait_q;
    logic spi_q;
    logic shdn;

    assign shdn = pin_level[`PIN_SHDN];

    // pin meaning follows the mode bit; field bit 4 is software pd
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            swing_q <= '0;
            dir_q <= 1'b0;
            d2_q <= 1'b0;
            d4_q <= 1'b0;
            off_q <= 1'b0;
            out_off_q <= 1'b0;
        end else begin
            swing_q <= {vco_swing_hi, vco_swing_lo};
            dir_q <= output_path_field[1:0] == `PATH_DIRECT;
            d2_q <= output_path_field[1:0] == `PATH_DIV2;
            d4_q <= output_path_field[1:0] == `PATH_DIV4;
            off_q <= (!pin_mode_select && shdn) ||
                     output_path_field[`PATH_SW_PD_BIT];
            out_off_q <= shdn;
        end
    end

    // strap caught once the synchroniser has settled after reset;
    // the stable flop needs four edges, so the last capture is at five
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            strap_wait_q <= '0;
            spi_q <= 1'b0;
        end else if (strap_wait_q != `STRAP_WAIT) begin
            strap_wait_q <= strap_wait_q + 3'h1;
            spi_q <= pin_level[`PIN_STRAP];
        end
    end

    a_pd_mode: assert property (@(posedge mclk) disable iff (!rst_n)
        pin_mode_select && $stable(pin_mode_select) && shdn
        && !output_path_field[`PATH_SW_PD_BIT]
        && $stable(output_path_field) |=> out_off_q && !off_q)
        else $error("output gate mode powered device down");

    ////////////////////////////////////////////////////////////////////
    // outputs, all from flops
    assign modulus_19 = modulus_19_q;
    assign modulus_ctrl = modulus_ctrl_q;
    assign pfd_up = up_q;
    assign pfd_down = dn_q;
    assign lock_detect = lock_q;
    assign pump_source_on = src_q;
    assign pump_sink_on = snk_q;
    assign pump_level = level_q;
    assign pump_mid_hold = hold_q;
    assign vco_cal_start = cal_flag_q;
    assign vco_band = band_q;
    assign vco_swing = swing_q;
    assign path_direct = dir_q;
    assign path_div2 = d2_q;
    assign path_div4 = d4_q;
    assign device_off = off_q;
    assign output_stage_off = out_off_q;
    assign host_iface_spi = spi_q;

endmodule : pll_ctrl_top

// ===== rtl/pll_ctrl_defines.svh
// shared widths, field codes and timing counts of the synth control core
`ifndef PLL_CTRL_DEFINES_SVH
`define PLL_CTRL_DEFINES_SVH

`define MAIN_W 12
`define SWAL_W 5
`define RDIV_W 10
`define BAND_W 5
`define CP_CODE_W 3
`define CP_LEVEL_W 4
`define GAP_W 8
`define PIN_CNT 4
`define PIN_REF 0
`define PIN_PRESC 1
`define PIN_SHDN 2
`define PIN_STRAP 3

// search starts from the middle sub-band, top trial bit first
`define BAND_INIT 5'h10
`define BAND_BIT_INIT 5'h10

// output path code in the low bits of the path field
`define PATH_DIRECT 2'h0
`define PATH_DIV2 2'h1
`define PATH_DIV4 2'h2
`define PATH_SW_PD_BIT 4

// clock and lock-window timing, window is a longest time: round down
`define CLK_PERIOD_PS 4000
`define LOCK_DELAY_PS 5000
`define LOCK_WIN_CYC 8'((`LOCK_DELAY_PS) / (`CLK_PERIOD_PS))

// comparison periods of one calibration run
`define CAL_PERIODS 7
`define STRAP_WAIT 3'h5

`endif

// ===== rtl/pll_ctrl_pkg.sv
// types shared by the synth control core
package pll_ctrl_pkg;

    typedef enum {
        CAL_IDLE,
        CAL_SETTLE,
        CAL_SEARCH,
        CAL_FINISH
    } cal_state_t;

    typedef logic [4:0] band_t;

endpackage : pll_ctrl_pkg

// ===== rtl/fb_div_if.sv
// carrier between the control top and the feedback divider
`timescale 1ns/1ps
`include "pll_ctrl_defines.svh"

interface fb_div_if;
    logic [`MAIN_W-1:0] main_count;
    logic [`SWAL_W-1:0] swallow_count;
    logic presc_edge;
    logic fb_tick;
    logic mod_ctrl;

    modport ctrl (output main_count, output swallow_count,
                  output presc_edge, input fb_tick, input mod_ctrl);
    modport div (input main_count, input swallow_count,
                 input presc_edge, output fb_tick, output mod_ctrl);
endinterface : fb_div_if

// ===== rtl/fb_divider.sv
// swallow and main counters of the dual-modulus feedback divider
`timescale 1ns/1ps
`include "pll_ctrl_defines.svh"

module fb_divider (
    input wire logic mclk, // core clock
    input wire logic rst_n, // async reset, active low
    fb_div_if.div bus // counts in, tick and modulus out
);

    logic [`MAIN_W-1:0] main_left_q;
    logic [`SWAL_W-1:0] swal_left_q;
    logic tick_q;
    logic wrap;

    assign wrap = (main_left_q <= `MAIN_W'(1));

    // main counts every prescaler cycle, swallow only the first ones
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            main_left_q <= '0;
            swal_left_q <= '0;
        end else if (bus.presc_edge) begin
            if (wrap) begin
                main_left_q <= bus.main_count;
                swal_left_q <= bus.swallow_count;
            end else begin
                main_left_q <= main_left_q - `MAIN_W'(1);
                if (swal_left_q != '0) begin
                    swal_left_q <= swal_left_q - `SWAL_W'(1);
                end
            end
        end
    end

    // one pulse per full count: A cycles at P+1 plus B-A cycles at P
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= bus.presc_edge && wrap;
        end
    end

    assign bus.fb_tick = tick_q;
    // high asks the prescaler for P+1 while swallow cycles remain
    assign bus.mod_ctrl = (swal_left_q != '0);

    a_fb_reload: assert property (@(posedge mclk) disable iff (!rst_n)
        bus.presc_edge && wrap |=> main_left_q == $past(bus.main_count)
        && swal_left_q == $past(bus.swallow_count) && tick_q)
        else $error("feedback counters not reloaded on wrap");

endmodule : fb_divider

// ===== test/ref_presc_model.sv
// reference oscillator and dual-modulus prescaler model
`timescale 1ns/1ps

module ref_presc_model (
    input wire logic mclk, // core clock, one vco unit per cycle
    input wire logic [7:0] ref_half, // reference half period in cycles
    input wire logic modulus_19, // modulus select from the core
    input wire logic modulus_ctrl, // ask for modulus plus one
    output logic ref_pin, // free running reference clock
    output logic presc_pin // prescaler output
);
    logic [7:0] rc_q = 8'h00;
    logic [4:0] pc_q = 5'h00;
    logic ref_q = 1'b0;

    // reference oscillator runs free, never stops between ticks
    always_ff @(posedge mclk) begin
        rc_q <= (rc_q >= ref_half - 8'h01) ? 8'h00 : rc_q + 8'h01;
        ref_q <= (rc_q >= ref_half - 8'h01) ? ~ref_q : ref_q;
    end
    assign ref_pin = ref_q;

    // period is P or P+1 units, modulus sampled at each period start
    always_ff @(posedge mclk) begin
        if (pc_q == 5'h00) begin
            pc_q <= (modulus_19 ? 5'h12 : 5'h0F) + 5'(modulus_ctrl);
        end else begin
            pc_q <= pc_q - 5'h01;
        end
    end
    // high for the upper part of the count, rises at each reload
    assign presc_pin = (pc_q > 5'h07);
endmodule : ref_presc_model

// ===== test/pll_synth_digital_control_tb.sv
// self-checking bench of the synth control core
`timescale 1ns/1ps

module pll_synth_digital_control_tb;
    logic mclk, rst_n, ref_pin, presc_pin, shdn, m19, calw, pmode;
    logic b2, b1, b0, sw_hi, sw_lo;
    logic [9:0] rdiv;
    logic [11:0] mainc;
    logic [4:0] swal, pathf;
    logic [7:0] rhalf;
    logic mod19, mctl, up, dn, lock, src, snk, hold, cal, pd3, p2, p4;
    logic doff, ooff, spi;
    logic [3:0] lvl;
    logic [4:0] band;
    logic [1:0] swing;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;

    pll_ctrl_top dut_u (.mclk(mclk), .rst_n(rst_n), .ref_clk_pin(ref_pin),
        .presc_out_pin(presc_pin), .ext_shutdown_pin(shdn),
        .host_iface_strap(1'b1), .ref_div_ratio(rdiv), .main_count(mainc),
        .swallow_count(swal), .modulus_19_sel(m19), .cal_start_write(calw),
        .cal_restart_enable(1'b1), .cp_current_code_b2(b2),
        .cp_current_code_b1(b1), .cp_current_code_b0(b0),
        .vco_swing_hi(sw_hi), .vco_swing_lo(sw_lo), .output_path_field(pathf),
        .pin_mode_select(pmode), .modulus_19(mod19), .modulus_ctrl(mctl),
        .pfd_up(up), .pfd_down(dn), .lock_detect(lock), .pump_source_on(src),
        .pump_sink_on(snk), .pump_level(lvl), .pump_mid_hold(hold),
        .vco_cal_start(cal), .vco_band(band), .vco_swing(swing),
        .path_direct(pd3), .path_div2(p2), .path_div4(p4), .device_off(doff),
        .output_stage_off(ooff), .host_iface_spi(spi));

    ref_presc_model far_u (.mclk(mclk), .ref_half(rhalf), .modulus_19(mod19),
        .modulus_ctrl(mctl), .ref_pin(ref_pin), .presc_pin(presc_pin));

    // clock and cycle count for duration checks
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) cyc++;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : tally_and_finish

    // pump level, swing and path follow their codes
    task automatic t_codes();
        for (int k = 0; k < 8; k++) begin
            {b2, b1, b0} = 3'(k);
            sw_hi = k[1];
            sw_lo = k[0];
            // path code 3 selects no path at all
            pathf = 5'(k % 4);
            repeat (2) @(negedge mclk);
            chk(16'(lvl), 16'(k + 1));
            chk(16'(swing), 16'(k % 4));
            chk(16'({pd3, p2, p4}), 16'(4 >> (k % 4)));
        end
    endtask : t_codes

    // shutdown pin in both pin modes, sync latency allowed
    task automatic t_shdn();
        shdn = 1'b1;
        repeat (8) @(negedge mclk);
        chk(16'({doff, ooff}), 16'h0003);
        pmode = 1'b1;
        repeat (8) @(negedge mclk);
        chk(16'({doff, ooff}), 16'h0001);
        shdn = 1'b0;
        repeat (8) @(negedge mclk);
        chk(16'({doff, ooff}), 16'h0000);
        pathf = 5'h10;
        repeat (2) @(negedge mclk);
        chk(16'(doff), 16'h0001);
        pathf = 5'h00;
    endtask : t_shdn

    // spacing of detector down pulses equals B*P+A units
    task automatic t_fb(input logic m);
        int t0;
        m19 = m;
        mainc = m ? 12'h014 : 12'h010;
        rhalf = m ? 8'h60 : 8'h41;
        repeat (900) @(negedge mclk);
        chk(16'(mod19), 16'(m));
        for (int j = 0; j < 2; j++) begin
            t0 = cyc;
            while (dn !== 1'b1 && cyc - t0 < 800) @(negedge mclk);
            while (dn !== 1'b0 && cyc - t0 < 800) @(negedge mclk);
            while (dn !== 1'b1 && cyc - t0 < 800) @(negedge mclk);
            if (j == 0) t0 = cyc;
        end
        chk(16'(cyc - t0), 16'(m ? 20 * 19 + 4 : 16 * 16 + 4));
    endtask : t_fb

    // one calibration run: pump held mid, start bit self-clears
    // comparison period is four half periods, reference ratio being two
    task automatic t_cal(input logic [7:0] h, input logic [4:0] exp_band);
        int t0;
        int per;
        per = 4 * h;
        rhalf = h;
        calw = 1'b1;
        @(negedge mclk);
        calw = 1'b0;
        chk(16'({cal, hold, src, snk}), 16'h000C);
        t0 = cyc;
        while (cal !== 1'b0 && cyc - t0 < 6000) @(negedge mclk);
        chk(16'(cyc - t0 >= 6 * per && cyc - t0 <= 7 * per + 8), 1);
        chk(16'({cal, hold}), 16'h0000);
        chk(16'(band), 16'(exp_band));
    endtask : t_cal

    initial begin
        rst_n = 1'b0;
        {shdn, m19, calw, pmode, b2, b1, b0, sw_hi, sw_lo} = '0;
        // comparison period 4 * rhalf equals N = B*P+A feedback units
        rdiv = 10'h002;
        mainc = 12'h010;
        swal = 5'h04;
        pathf = 5'h00;
        rhalf = 8'h41;
        repeat (12) @(negedge mclk);
        rst_n = 1'b1;
        @(negedge mclk);
        chk(16'({band, lvl}), 16'h0101);
        repeat (6) @(negedge mclk);
        chk(16'(spi), 16'h0001);
        t_codes();
        t_shdn();
        t_fb(1'b0);
        t_fb(1'b1);
        // equal rates never read as fast; doubled period always does
        t_cal(8'h60, 5'h1F);
        t_cal(8'hC0, 5'h00);
        tally_and_finish();
    end

    // watchdog: whole run is some 11000 cycles
    initial begin
        #200000;
        n_fail++;
        tally_and_finish();
    end
endmodule : pll_synth_digital_control_tb
